//--- common/dprc_pkg.sv
package dprc_pkg;

    // Port geometry: 2048 words of two bytes
    localparam int ADDR_W  = 11;
    localparam int DATA_W  = 16;
    localparam int LANES   = 2;
    localparam int CNT_W   = 8;

    // Clock period and pin timing, in ns as printed
    localparam int CLK_NS        = 10;
    localparam int ARB_MAX_NS    = 45;   // Master worst arbitration time
    localparam int WR_HOLD_NS    = 30;   // write_hold_after_contention
    localparam int WR_PULSE_NS   = 40;   // Least write pulse
    localparam int RD_ACCESS_NS  = 90;   // Read access from select
    localparam int PORT_DELAY_NS = 70;   // Port-to-port data delay
    localparam int SYNC_STAGES   = 2;    // Input synchroniser latency

    // Least times round up to whole cycles
    localparam int ARB_CYC   = (ARB_MAX_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC  = (WR_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC   = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
    localparam int PORT_CYC  = (PORT_DELAY_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;

    // Inactive pin levels
    localparam logic PIN_IDLE_N = 1'b1;

    // User request toward the port
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [LANES-1:0]  be;      // Bit 0 lower byte, bit 1 upper byte
    } dprc_req_t;

    // Completed access back to the user
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
        logic              contended;
    } dprc_rsp_t;

    // Pins driven toward one memory port
    typedef struct packed {
        logic              select_n;
        logic              lower_byte_write_strobe_n;
        logic              upper_byte_write_strobe_n;
        logic              out_enable_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_o;
        logic              dq_oe;
    } dprc_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SELECT,
        ST_ARB,
        ST_PULSE,
        ST_WR_END,
        ST_READ
    } dprc_state_t;

endpackage

//--- src/dprc_sync.sv
`timescale 1ns/100ps
module dprc_sync #(
    parameter int            WIDTH    = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_nrst,
    // Asynchronous level in, synchronised level out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;

    // Two stages; first stage feeds only the second
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule

//--- src/dprc_port_ctrl.sv
`timescale 1ns/100ps
module dprc_port_ctrl
    import dprc_pkg::*;
#(
    parameter int ARB_CYCLES   = ARB_CYC,
    parameter int HOLD_CYCLES  = HOLD_CYC,
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int ACC_CYCLES   = ACC_CYC,
    parameter int PORT_CYCLES  = PORT_CYC
) (
    // Clock and reset
    input  wire logic            i_clk_sys,
    input  wire logic            i_nrst,
    // User request
    input  wire logic            i_req_valid,
    input  wire dprc_pkg::dprc_req_t i_req,
    output logic                 o_req_ready,
    // User response
    output dprc_pkg::dprc_rsp_t  o_rsp,
    // Memory port pins
    output dprc_pkg::dprc_pins_t o_pins,
    input  wire logic [dprc_pkg::DATA_W-1:0] i_dq_i,
    input  wire logic            i_contention_flag_n
);
    import dprc_pkg::*;

    // Whole sequencer state
    typedef struct packed {
        dprc_state_t      st;
        logic [CNT_W-1:0] cnt;
        logic             ready;
        dprc_rsp_t        rsp;
        dprc_pins_t       pins;
    } dprc_ctl_t;

    localparam dprc_pins_t PINS_RST = '{
        select_n:                  PIN_IDLE_N,
        lower_byte_write_strobe_n: PIN_IDLE_N,
        upper_byte_write_strobe_n: PIN_IDLE_N,
        out_enable_n:              PIN_IDLE_N,
        addr:                      '0,
        dq_o:                      '0,
        dq_oe:                     1'b0
    };
    localparam dprc_ctl_t CTL_RST = '{
        st:    ST_IDLE,
        cnt:   '0,
        ready: 1'b0,
        rsp:   '0,
        pins:  PINS_RST
    };

    // Counter loads; every figure is at least one cycle
    function automatic logic [CNT_W-1:0] load(input int cycles);
        load = (cycles > 1) ? CNT_W'(cycles - 1) : '0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    ////////////////////////////////////////////////////////////////////////////////

    logic [1:0]        rst_q;
    logic              rst_n;
    logic [DATA_W-1:0] dq_s;
    logic              flag_n_s;

    // Asynchronous assert, two-stage release
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // Data and flag both cross from the pins
    dprc_sync #(
        .WIDTH   (DATA_W + 1),
        .RST_VAL ({{DATA_W{1'b0}}, 1'b1})
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (rst_n),
        .i_async   ({i_dq_i, i_contention_flag_n}),
        .o_sync    ({dq_s, flag_n_s})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Access sequencer
    ////////////////////////////////////////////////////////////////////////////////

    dprc_ctl_t ctl_q;
    dprc_ctl_t ctl_d;

    always_comb begin
        ctl_d = ctl_q;
        ctl_d.rsp.valid = 1'b0;
        unique case (ctl_q.st)
            ST_IDLE: begin
                ctl_d.pins.select_n     = PIN_IDLE_N;
                ctl_d.pins.out_enable_n = PIN_IDLE_N;
                ctl_d.ready             = 1'b1;
                if (i_req_valid && ctl_q.ready) begin
                    ctl_d.pins.addr          = i_req.addr;
                    ctl_d.pins.dq_o          = i_req.wdata;
                    ctl_d.rsp.rdata          = '0;
                    ctl_d.rsp.contended      = 1'b0;
                    ctl_d.ready              = 1'b0;
                    ctl_d.st                 = ST_SELECT;
                    ctl_d.pins.out_enable_n  = i_req.write;
                    // Strobe pattern parked in the counter until select; keep enables
                    ctl_d.cnt = {{(CNT_W-LANES){1'b0}}, i_req.be};
                    ctl_d.rsp.rdata[0] = i_req.write;
                end
            end
            ST_SELECT: begin
                ctl_d.pins.select_n = 1'b0;
                if (ctl_q.rsp.rdata[0]) begin
                    ctl_d.rsp.rdata = {{(DATA_W-LANES){1'b0}}, ctl_q.cnt[LANES-1:0]};
                    ctl_d.cnt       = load(ARB_CYCLES);
                    ctl_d.st        = ST_ARB;
                end else begin
                    ctl_d.cnt = load(ACC_CYCLES);
                    ctl_d.st  = ST_READ;
                end
            end
            ST_ARB: begin
                // wait out the master's arbitration first
                if (ctl_q.cnt == '0) begin
                    // both strobes when both lanes enabled
                    // one strobe writes just its byte
                    ctl_d.pins.lower_byte_write_strobe_n = ~ctl_q.rsp.rdata[0];
                    ctl_d.pins.upper_byte_write_strobe_n = ~ctl_q.rsp.rdata[1];
                    // device outputs off since enable is high
                    ctl_d.pins.dq_oe = 1'b1;
                    ctl_d.cnt        = load(PULSE_CYCLES);
                    ctl_d.st         = ST_PULSE;
                end else begin
                    ctl_d.cnt = ctl_q.cnt - 1'b1;
                end
            end
            ST_PULSE: begin
                if (!flag_n_s) begin
                    ctl_d.cnt           = load(HOLD_CYCLES);
                    ctl_d.rsp.contended = 1'b1;
                end else if (ctl_q.cnt == '0) begin
                    // strobes rise, ending the write overlap
                    ctl_d.pins.lower_byte_write_strobe_n = PIN_IDLE_N;
                    ctl_d.pins.upper_byte_write_strobe_n = PIN_IDLE_N;
                    ctl_d.st = ST_WR_END;
                end else begin
                    ctl_d.cnt = ctl_q.cnt - 1'b1;
                end
            end
            ST_WR_END: begin
                // Data held one cycle past strobe rise
                ctl_d.pins.dq_oe    = 1'b0;
                ctl_d.pins.select_n = PIN_IDLE_N;
                ctl_d.rsp.valid     = 1'b1;
                ctl_d.rsp.rdata     = '0;
                ctl_d.st            = ST_IDLE;
            end
            ST_READ: begin
                // enable low, strobes high reads both lanes
                if (!flag_n_s) begin
                    // data waits for release plus port delay
                    ctl_d.cnt           = load(PORT_CYCLES);
                    ctl_d.rsp.contended = 1'b1;
                end else if (ctl_q.cnt == '0) begin
                    ctl_d.rsp.rdata         = dq_s;
                    ctl_d.rsp.valid         = 1'b1;
                    ctl_d.pins.out_enable_n = PIN_IDLE_N;
                    ctl_d.pins.select_n     = PIN_IDLE_N;
                    ctl_d.st                = ST_IDLE;
                end else begin
                    ctl_d.cnt = ctl_q.cnt - 1'b1;
                end
            end
        endcase
    end

    // Single state register
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= CTL_RST;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // Outputs straight from the state register
    assign o_req_ready = ctl_q.ready;
    assign o_rsp       = ctl_q.rsp;
    assign o_pins      = ctl_q.pins;

endmodule

//--- verification/dprc_port_ctrl_properties.sv
`timescale 1ns/100ps
module dprc_checker
    import dprc_pkg::*;
#(
    parameter int ARB_CYCLES = ARB_CYC
) (
    // Clock and reset
    input wire logic                 i_clk_sys,
    input wire logic                 i_nrst,
    // User side
    input wire logic                 i_req_valid,
    input wire dprc_pkg::dprc_req_t  i_req,
    input wire logic                 o_req_ready,
    input wire dprc_pkg::dprc_rsp_t  o_rsp,
    // Memory side
    input wire dprc_pkg::dprc_pins_t o_pins,
    input wire logic                 i_contention_flag_n
);
    logic wr_low;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    // Any byte strobe low
    assign wr_low = !o_pins.lower_byte_write_strobe_n || !o_pins.upper_byte_write_strobe_n;

    addr_stable_a: assert property (o_pins.addr != $past(o_pins.addr)
        |-> o_pins.select_n && $past(o_pins.select_n)) else $error("address moved while selected");
    no_bus_clash_a: assert property (o_pins.dq_oe |-> o_pins.out_enable_n)
        else $error("data driven while output enable low");
    oe_high_write_a: assert property (wr_low |-> o_pins.out_enable_n)
        else $error("write with output enable low");
    strobe_select_a: assert property (wr_low |-> !o_pins.select_n && o_pins.dq_oe)
        else $error("strobe outside select or without data");
    arb_delay_a: assert property ($rose(wr_low) |-> !$past(o_pins.select_n, ARB_CYCLES)
        && $past(o_pins.select_n, ARB_CYCLES + 1)) else $error("strobe not one arbitration after select");
    pulse_width_a: assert property ($rose(wr_low) |-> wr_low [*4])
        else $error("write pulse too short");
    flag_hold_a: assert property (wr_low && $rose(i_contention_flag_n) |=> wr_low [*3])
        else $error("write released before hold after contention");
    answer_bound_a: assert property (i_req_valid && o_req_ready
        |-> ##[1:400] o_rsp.valid) else $error("no response to accepted request");
endmodule

// Checker rides on every port controller
bind dprc_port_ctrl dprc_checker #(.ARB_CYCLES(ARB_CYCLES)) u_chk (.i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_rsp(o_rsp), .o_pins(o_pins), .i_contention_flag_n(i_contention_flag_n));

//--- verification/dprc_mem_model.sv
`timescale 1ns/100ps
module dprc_mem_model
    import dprc_pkg::*;
(
    // Left pins from the controller, right pins from the bench
    input  wire dprc_pkg::dprc_pins_t        i_left,
    input  wire logic [dprc_pkg::DATA_W-1:0] i_left_dq,
    input  wire dprc_pkg::dprc_pins_t        i_right,
    // Left read data and flags after pull-up
    output logic [dprc_pkg::DATA_W-1:0]      o_left_dq,
    output logic                             o_left_flag_n,
    output logic                             o_right_flag_n
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] last_q = '0;
    logic [LANES-1:0]  drv;
    logic              match;
    realtime           l_t, r_t;
    wire [DATA_W-1:0]  rd = mem[i_left.addr];

    // last select fall or address move marks when a port settled
    always @(i_left.addr or negedge i_left.select_n) l_t = $realtime;
    always @(i_right.addr or negedge i_right.select_n) r_t = $realtime;

    assign match = !i_left.select_n && !i_right.select_n && i_left.addr == i_right.addr;
    assign o_left_flag_n = !(match && r_t < l_t);
    assign o_right_flag_n = !(match && !(r_t < l_t));

    // same gate a slave applies to the master's flag
    always @* begin
        if (!i_left.select_n && o_left_flag_n) begin
            if (!i_left.lower_byte_write_strobe_n) mem[i_left.addr][7:0] = i_left_dq[7:0];
            if (!i_left.upper_byte_write_strobe_n) mem[i_left.addr][15:8] = i_left_dq[15:8];
        end
        if (!i_right.select_n && o_right_flag_n && !i_right.lower_byte_write_strobe_n)
            mem[i_right.addr] = i_right.dq_o;
    end

    // lanes driven only when read; else, or flagged, garbage
    assign drv[0] = !i_left.select_n && !i_left.out_enable_n && i_left.lower_byte_write_strobe_n;
    assign drv[1] = !i_left.select_n && !i_left.out_enable_n && i_left.upper_byte_write_strobe_n;
    always @* begin
        for (int b = 0; b < LANES; b++) begin
            if (drv[b]) last_q[b*8 +: 8] = rd[b*8 +: 8];
            o_left_dq[b*8 +: 8] = (drv[b] && o_left_flag_n) ? rd[b*8 +: 8] : ~last_q[b*8 +: 8];
        end
    end
endmodule

//--- verification/test_dual_port_ram_contention_arbiter.sv
`timescale 1ns/100ps
module test_dual_port_ram_contention_arbiter;
    import dprc_pkg::*;
    logic              i_clk_sys = 1'b0;
    logic              i_nrst = 1'b0;
    logic              req_valid = 1'b0;
    dprc_req_t         req = '0;
    logic              req_ready, flag_n;
    dprc_rsp_t         rsp;
    dprc_pins_t        pins;
    dprc_pins_t        right = '1;
    logic [DATA_W-1:0] mem_dq, dq_bus;
    int                failures = 0;
    int                comparisons = 0;

    // Shared data pins: controller drives only with its enable
    assign dq_bus = pins.dq_oe ? pins.dq_o : mem_dq;

    dprc_port_ctrl dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req_valid(req_valid),
        .i_req(req), .o_req_ready(req_ready), .o_rsp(rsp), .o_pins(pins), .i_dq_i(dq_bus),
        .i_contention_flag_n(flag_n));
    dprc_mem_model u_mem (.i_left(pins), .i_left_dq(dq_bus), .i_right(right),
        .o_left_dq(mem_dq), .o_left_flag_n(flag_n), .o_right_flag_n());

    // Clock at 100 MHz
    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic check16(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(string what, logic exp, logic got);
        check16(what, {15'h0000, exp}, {15'h0000, got});
    endtask

    // One request, bounded waits for ready and answer
    task automatic access(logic wr, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic [1:0] be);
        int n = 0;
        while (req_ready !== 1'b1 && n < 300) begin
            @(posedge i_clk_sys); #1; n++;
        end
        req = '{write: wr, addr: a, wdata: d, be: be};
        req_valid = 1'b1;
        @(posedge i_clk_sys); #1;
        req_valid = 1'b0;
        check1("ready while busy", 1'b0, req_ready);
        n = 0;
        while (rsp.valid !== 1'b1 && n < 300) begin
            @(posedge i_clk_sys); #1; n++;
        end
        check1("response", 1'b1, rsp.valid);
    endtask

    task automatic t_bytes();
        access(1'b1, 11'h7FF, 16'hA5C3, 2'b11);
        access(1'b1, 11'h000, 16'h0F0F, 2'b11);
        access(1'b0, 11'h7FF, 16'h0000, 2'b00);
        check16("full word", 16'hA5C3, rsp.rdata);
        check1("no contention", 1'b0, rsp.contended);
        access(1'b1, 11'h7FF, 16'h1E2D, 2'b01);
        access(1'b0, 11'h7FF, 16'h0000, 2'b00);
        check16("lower byte", 16'hA52D, rsp.rdata);
        access(1'b1, 11'h7FF, 16'h4B6F, 2'b10);
        access(1'b0, 11'h7FF, 16'h0000, 2'b00);
        check16("upper byte", 16'h4B2D, rsp.rdata);
        // No lane enabled: the write runs with no strobe
        access(1'b1, 11'h7FF, 16'hFFFF, 2'b00);
        access(1'b0, 11'h7FF, 16'h0000, 2'b00);
        check16("no strobe write", 16'h4B2D, rsp.rdata);
        $display("test bytes done");
    endtask

    task automatic t_contend_write();
        access(1'b1, 11'h155, 16'h0000, 2'b11);
        right.addr = 11'h156;
        right.select_n = 1'b0;
        access(1'b1, 11'h155, 16'h1111, 2'b11);
        check1("other address", 1'b0, rsp.contended);
        // right settles cycles ahead of the left select
        right.addr = 11'h155;
        // Right selects first, so the left write must lose and wait
        fork
            begin
                repeat (15) @(posedge i_clk_sys);
                #1 check16("suppressed write", 16'h1111, u_mem.mem[11'h155]);
                repeat (10) @(posedge i_clk_sys);
                #1 right.select_n = 1'b1;
            end
            access(1'b1, 11'h155, 16'hC3A5, 2'b11);
        join
        check1("write flagged", 1'b1, rsp.contended);
        access(1'b0, 11'h155, 16'h0000, 2'b00);
        check16("write after release", 16'hC3A5, rsp.rdata);
        $display("test contended write done");
    endtask

    task automatic t_contend_read();
        // right selects well before the left read
        right.select_n = 1'b0;
        fork
            begin
                repeat (25) @(posedge i_clk_sys);
                #1 right.select_n = 1'b1;
            end
            access(1'b0, 11'h155, 16'h0000, 2'b00);
        join
        check1("read flagged", 1'b1, rsp.contended);
        check16("read after release", 16'hC3A5, rsp.rdata);
        $display("test contended read done");
    endtask

    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge i_clk_sys);
        #1 i_nrst = 1'b1;
        t_bytes();
        t_contend_write();
        t_contend_read();
        give_verdict();
    end

    // Watchdog: tests take a few hundred cycles at most
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
endmodule
